/* File: src/accel_fmt_defs.svh */
`ifndef ACCEL_FMT_DEFS_SVH
`define ACCEL_FMT_DEFS_SVH

// Register offsets on the plain register port (byte addresses)
`define OFS_DECIMATION 8'h00
`define OFS_AVERAGING 8'h04
`define OFS_X_UPPER 8'h08
`define OFS_Y_UPPER 8'h0C
`define OFS_Z_UPPER 8'h10
`define OFS_X_EXT 8'h14
`define OFS_Y_EXT 8'h18
`define OFS_Z_EXT 8'h1C
`define OFS_BURST 8'h20
`define OFS_STATUS 8'h24

// Reset values
`define DECIMATION_RESET 16'h0000
`define AVERAGING_RESET 3'h0

// Field layout of the status register
`define STATUS_WIDTH_LSB 0
`define STATUS_WIDTH_MSB 5
`define STATUS_NEW_BIT 8

// Widths of the result and number of axes
`define BASE_WIDTH 6'h14
`define UPPER_BITS 16
`define COMBINED_BITS 32
`define AXIS_COUNT 3

`endif

/* File: src/accel_fmt_pkg.sv */
package accel_fmt_pkg;

    typedef logic [5:0] width_t;

    typedef enum logic [2:0]
    {
        BURST_X = 3'h1,
        BURST_Y = 3'h2,
        BURST_Z = 3'h4
    } burst_sel_t;

endpackage

/* File: src/fmt_if.sv */
`timescale 1ns/1ps

interface fmt_if
    import accel_fmt_pkg::*;
#(
    parameter int ACC_W = 50
);
    logic load;
    logic [ACC_W-1:0] result;
    width_t width;
    logic [15:0] upper;
    logic [15:0] extension;

    modport source (output load, output result, output width,
                    input upper, input extension);
    modport sink (input load, input result, input width,
                  output upper, output extension);
endinterface

/* File: src/width_calc.sv */
`timescale 1ns/1ps
`include "accel_fmt_defs.svh"

module width_calc
    import accel_fmt_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Filter settings
    input wire logic [15:0] decimation_setting,
    input wire logic [2:0] averaging_filter_setting,
    // Significant width of the result
    output width_t sig_width
);

    // Smallest n with 2**n >= v; rounds up so odd sums never overflow
    function automatic logic [4:0] ceil_log2(input logic [16:0] v);
        logic [4:0] n;
        n = 5'h0;
        for (int i = 0; i < 17; i++)
        begin
            if ((17'h1 << i) < v)
            begin
                n = 5'(i + 1);
            end
        end
        return n;
    endfunction

    wire [16:0] dec_terms = {1'b0, decimation_setting} + 17'h1;
    wire [5:0] dec_growth = {1'b0, ceil_log2(dec_terms)};
    wire [5:0] avg_growth = {3'h0, averaging_filter_setting};
    wire [5:0] next_width = `BASE_WIDTH + dec_growth + avg_growth
                            + avg_growth;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            sig_width <= `BASE_WIDTH;
        else
            sig_width <= next_width;
    end

endmodule

/* File: src/axis_formatter.sv */
`timescale 1ns/1ps
`include "accel_fmt_defs.svh"

module axis_formatter
    import accel_fmt_pkg::*;
#(
    parameter int ACC_W = 50
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Result in, formatted words out
    fmt_if.sink fmt
);

    // Left-justify the significant bits at the top of the accumulator
    wire [5:0] shift = 6'(ACC_W) - fmt.width;
    wire [ACC_W-1:0] aligned = fmt.result << shift;
    wire [`COMBINED_BITS-1:0] combined =
        aligned[ACC_W-1 -: `COMBINED_BITS];

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fmt.upper <= 16'h0000;
            fmt.extension <= 16'h0000;
        end
        else if (fmt.load)
        begin
            fmt.upper <= combined[31:16];
            fmt.extension <= combined[15:0];
        end
    end

endmodule

/* File: src/accel_output_width_formatter.sv */
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "accel_fmt_defs.svh"

module accel_output_width_formatter
    import accel_fmt_pkg::*;
#(
    parameter int SAMPLE_W = 20,
    parameter int ACC_W = 50
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Raw accelerometer samples
    input wire logic sample_valid,
    input wire logic [SAMPLE_W-1:0] sample_x,
    input wire logic [SAMPLE_W-1:0] sample_y,
    input wire logic [SAMPLE_W-1:0] sample_z,
    // Result strobe and width
    output logic result_valid,
    output width_t result_width
);

    localparam int AXES = `AXIS_COUNT;

    // Software settings
    logic [15:0] decimation_setting;
    logic [2:0] averaging_filter_setting;

    // Stage counters, shared by all axes
    logic [15:0] dec_cnt;
    logic [7:0] avg1_cnt;
    logic [7:0] avg2_cnt;

    // Stage valid strobes
    logic dec_valid;
    logic avg1_valid;
    logic avg2_valid;

    // Burst pointer and new data flag
    burst_sel_t burst_sel;
    logic new_data;

    // Per axis data
    logic [SAMPLE_W-1:0] raw [AXES];
    logic [ACC_W-1:0] dec_acc [AXES];
    logic [ACC_W-1:0] dec_out [AXES];
    logic [ACC_W-1:0] avg1_acc [AXES];
    logic [ACC_W-1:0] avg1_out [AXES];
    logic [ACC_W-1:0] avg2_acc [AXES];
    logic [ACC_W-1:0] avg2_out [AXES];
    logic [ACC_W-1:0] dec_sum [AXES];
    logic [ACC_W-1:0] avg1_sum [AXES];
    logic [ACC_W-1:0] avg2_sum [AXES];

    width_t sig_width;

    fmt_if #(.ACC_W(ACC_W)) fmt [AXES] ();

    assign raw[0] = sample_x;
    assign raw[1] = sample_y;
    assign raw[2] = sample_z;

    // Register decode
    wire wr_dec = reg_wr && (reg_addr == `OFS_DECIMATION);
    wire wr_avg = reg_wr && (reg_addr == `OFS_AVERAGING);
    wire rd_burst = reg_rd && (reg_addr == `OFS_BURST);
    wire rd_status = reg_rd && (reg_addr == `OFS_STATUS);

    // A new setting flushes partial sums so no result mixes two widths
    wire restart = wr_dec || wr_avg;

    // stage length two to the N
    wire [7:0] avg_last = 8'((9'h001 << averaging_filter_setting) - 9'h001);

    // decimation stage ends after N plus one
    wire dec_done = sample_valid && (dec_cnt == decimation_setting);
    wire avg1_done = dec_valid && (avg1_cnt == avg_last);
    wire avg2_done = avg1_valid && (avg2_cnt == avg_last);

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            decimation_setting <= `DECIMATION_RESET;
            averaging_filter_setting <= `AVERAGING_RESET;
        end
        else
        begin
            if (wr_dec)
                decimation_setting <= reg_wdata;
            if (wr_avg)
                averaging_filter_setting <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dec_cnt <= 16'h0000;
            avg1_cnt <= 8'h00;
            avg2_cnt <= 8'h00;
        end
        else if (restart)
        begin
            dec_cnt <= 16'h0000;
            avg1_cnt <= 8'h00;
            avg2_cnt <= 8'h00;
        end
        else
        begin
            if (sample_valid)
                dec_cnt <= dec_done ? 16'h0000 : dec_cnt + 16'h0001;
            if (dec_valid)
                avg1_cnt <= avg1_done ? 8'h00 : avg1_cnt + 8'h01;
            if (avg1_valid)
                avg2_cnt <= avg2_done ? 8'h00 : avg2_cnt + 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dec_valid <= 1'b0;
            avg1_valid <= 1'b0;
            avg2_valid <= 1'b0;
            result_valid <= 1'b0;
        end
        else
        begin
            dec_valid <= dec_done && !restart;
            avg1_valid <= avg1_done && !restart;
            avg2_valid <= avg2_done && !restart;
            result_valid <= avg2_valid && !restart;
        end
    end

    genvar a;
    generate
        for (a = 0; a < AXES; a++)
        begin : g_axis
            assign dec_sum[a] = dec_acc[a]
                + {{(ACC_W-SAMPLE_W){raw[a][SAMPLE_W-1]}}, raw[a]};
            assign avg1_sum[a] = avg1_acc[a] + dec_out[a];
            assign avg2_sum[a] = avg2_acc[a] + avg1_out[a];

            always_ff @(posedge core_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    dec_acc[a] <= '0;
                    dec_out[a] <= '0;
                end
                else if (restart)
                    dec_acc[a] <= '0;
                else if (sample_valid)
                begin
                    dec_acc[a] <= dec_done ? '0 : dec_sum[a];
                    dec_out[a] <= dec_sum[a];
                end
            end

            always_ff @(posedge core_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    avg1_acc[a] <= '0;
                    avg1_out[a] <= '0;
                end
                else if (restart)
                    avg1_acc[a] <= '0;
                else if (dec_valid)
                begin
                    avg1_acc[a] <= avg1_done ? '0 : avg1_sum[a];
                    avg1_out[a] <= avg1_sum[a];
                end
            end

            always_ff @(posedge core_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    avg2_acc[a] <= '0;
                    avg2_out[a] <= '0;
                end
                else if (restart)
                    avg2_acc[a] <= '0;
                else if (avg1_valid)
                begin
                    avg2_acc[a] <= avg2_done ? '0 : avg2_sum[a];
                    avg2_out[a] <= avg2_sum[a];
                end
            end

            assign fmt[a].load = avg2_valid && !restart;
            assign fmt[a].result = avg2_out[a];
            assign fmt[a].width = sig_width;

            axis_formatter #(.ACC_W(ACC_W)) u_fmt
            (
                .core_clk(core_clk),
                .resetn(resetn),
                .fmt(fmt[a])
            );
        end
    endgenerate

    width_calc u_width
    (
        .core_clk(core_clk),
        .resetn(resetn),
        .decimation_setting(decimation_setting),
        .averaging_filter_setting(averaging_filter_setting),
        .sig_width(sig_width)
    );

    // Width of the words now held, caught with each result
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            result_width <= `BASE_WIDTH;
        else if (avg2_valid && !restart)
            result_width <= sig_width;
    end

    // Set wins over the clear by a status read
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            new_data <= 1'b0;
        else if (result_valid)
            new_data <= 1'b1;
        else if (rd_status)
            new_data <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            burst_sel <= BURST_X;
        else if (rd_burst)
        begin
            unique case (burst_sel)
                BURST_X: burst_sel <= BURST_Y;
                BURST_Y: burst_sel <= BURST_Z;
                BURST_Z: burst_sel <= BURST_X;
                default: burst_sel <= BURST_X;
            endcase
        end
    end

    wire [15:0] burst_word =
        (burst_sel == BURST_Y) ? fmt[1].upper :
        (burst_sel == BURST_Z) ? fmt[2].upper : fmt[0].upper;

    wire [15:0] status_word = {7'h00, new_data, 2'h0, result_width};

    wire [15:0] read_mux =
        (reg_addr == `OFS_DECIMATION) ? decimation_setting :
        (reg_addr == `OFS_AVERAGING) ? {13'h0000, averaging_filter_setting} :
        (reg_addr == `OFS_X_UPPER) ? fmt[0].upper :
        (reg_addr == `OFS_Y_UPPER) ? fmt[1].upper :
        (reg_addr == `OFS_Z_UPPER) ? fmt[2].upper :
        (reg_addr == `OFS_X_EXT) ? fmt[0].extension :
        (reg_addr == `OFS_Y_EXT) ? fmt[1].extension :
        (reg_addr == `OFS_Z_EXT) ? fmt[2].extension :
        (reg_addr == `OFS_BURST) ? burst_word :
        (reg_addr == `OFS_STATUS) ? status_word : 16'h0000;

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= 16'h0000;
        else
            reg_rdata <= reg_rd ? read_mux : 16'h0000;
    end

endmodule

/* File: test/accel_fmt_assertions.sv */
`timescale 1ns/1ps
`include "accel_fmt_defs.svh"

module accel_fmt_assertions
    import accel_fmt_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Samples and results
    input wire logic sample_valid,
    input wire logic result_valid,
    input wire width_t result_width
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    logic [15:0] dec;
    logic [2:0] avg;

    function automatic logic [5:0] grow(input logic [15:0] d);
        logic [5:0] g;
        g = 6'h00;
        while ((17'h1 << g) < ({1'b0, d} + 17'h1))
            g = g + 6'h01;
        return g;
    endfunction

    function automatic logic [15:0] low_mask(input width_t w);
        return (w >= 6'h20) ? 16'h0000 : (16'h1 << (6'h20 - w)) - 16'h1;
    endfunction

    wire [5:0] exp_w = `BASE_WIDTH + grow(dec) + {2'h0, avg, 1'b0};
    wire rd_ext = reg_rd && (reg_addr == `OFS_X_EXT ||
        reg_addr == `OFS_Y_EXT || reg_addr == `OFS_Z_EXT);

    // Shadow of the settings, as the host wrote them
    always_ff @(posedge core_clk or negedge resetn)
        if (!resetn)
        begin
            dec <= 16'h0000;
            avg <= 3'h0;
        end
        else if (reg_wr && reg_addr == `OFS_DECIMATION)
            dec <= reg_wdata;
        else if (reg_wr && reg_addr == `OFS_AVERAGING)
            avg <= reg_wdata[2:0];

    // A write flushes the pipe, so only undisturbed samples count
    sequence quiet_sample;
        sample_valid && !reg_wr && !$past(reg_wr) && !$past(reg_wr, 2)
            && dec == 16'h0000 && avg == 3'h0 ##1 !reg_wr [*3];
    endsequence

    AST_RESET_WIDTH:
        assert property ($rose(resetn) |-> result_width == `BASE_WIDTH)
        else $error("width after reset is not twenty");
    AST_SINGLE_LATENCY:
        assert property (quiet_sample |-> ##[0:1] result_valid)
        else $error("unfiltered sample gave no result in time");
    AST_RESULT_WIDTH:
        assert property (result_valid |-> result_width == exp_w)
        else $error("result width does not match settings");
    AST_STATUS_WIDTH:
        assert property (reg_rd && reg_addr == `OFS_STATUS
            |=> reg_rdata[5:0] == $past(result_width))
        else $error("status width differs from result width");
    AST_EXT_LOW_ZERO:
        assert property (rd_ext
            |=> (reg_rdata & low_mask($past(result_width))) == 16'h0000)
        else $error("extension bits below the width are not zero");
    AST_DEC_READBACK:
        assert property (reg_rd && reg_addr == `OFS_DECIMATION
            |=> reg_rdata == dec)
        else $error("decimation setting read back wrong");
    AST_AVG_READBACK:
        assert property (reg_rd && reg_addr == `OFS_AVERAGING
            |=> reg_rdata == {13'h0000, avg})
        else $error("averaging setting read back wrong");
    AST_RD_QUIET:
        assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data without a read");
endmodule

/* File: test/reg_host.sv */
`timescale 1ns/1ps

module reg_host
(
    // Clock
    input wire logic core_clk,
    // Register port, master side
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        // Released data must not look held
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
endmodule

/* File: test/accel_output_width_formatter_tb.sv */
`timescale 1ns/1ps
`include "accel_fmt_defs.svh"

module accel_output_width_formatter_tb;
    logic core_clk;
    logic resetn;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic sample_valid;
    logic [19:0] sample_x;
    logic [19:0] sample_y;
    logic [19:0] sample_z;
    logic result_valid;
    logic [5:0] result_width;
    logic [15:0] rd_data;
    int error_cnt;
    int checked;
    int cycles;

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    reg_host reg_host_inst
    (
        .core_clk(core_clk),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata)
    );

    accel_output_width_formatter accel_output_width_formatter_inst
    (
        .core_clk(core_clk),
        .resetn(resetn),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .sample_valid(sample_valid),
        .sample_x(sample_x),
        .sample_y(sample_y),
        .sample_z(sample_z),
        .result_valid(result_valid),
        .result_width(result_width)
    );

    task automatic chk(input string what, input logic [15:0] got,
                       input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Same value on every sample, so the sum is value times count
    task automatic run(input logic [15:0] dec, input logic [2:0] avg);
        logic [15:0] d;
        logic [19:0] v [3];
        logic [31:0] e;
        int n;
        int w;
        longint s;
        v = '{20'hABCDE, 20'h12345, 20'h80001};
        n = (dec + 1) * (1 << (2 * avg));
        w = 20 + $clog2(dec + 1) + 2 * avg;
        reg_host_inst.wr(`OFS_DECIMATION, dec);
        reg_host_inst.wr(`OFS_AVERAGING, {13'h0000, avg});
        repeat (3) @(posedge core_clk);
        sample_x <= v[0];
        sample_y <= v[1];
        sample_z <= v[2];
        sample_valid <= 1'b1;
        repeat (n) @(posedge core_clk);
        sample_valid <= 1'b0;
        for (int i = 0; i < 20 && result_valid !== 1'b1; i++)
            @(negedge core_clk);
        chk("result_valid", {15'h0000, result_valid}, 16'h0001);
        for (int a = 0; a < 3; a++)
        begin
            s = $signed(v[a]) * n;
            e = 32'(s <<< (32 - w));
            reg_host_inst.rd(`OFS_X_UPPER + 8'(4 * a), d);
            chk("upper word", d, e[31:16]);
            reg_host_inst.rd(`OFS_X_EXT + 8'(4 * a), d);
            chk("extension word", d, e[15:0]);
            reg_host_inst.rd(`OFS_BURST, d);
            chk("burst word", d, e[31:16]);
        end
        reg_host_inst.rd(`OFS_STATUS, d);
        // New data flag must be up after the result, width in the low bits
        chk("status", d, 16'h0100 | 16'(w));
        $display("Test dec %0d avg %0d done", dec, avg);
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            end_sim();
        end
    end

    initial
    begin
        resetn = 1'b0;
        sample_valid = 1'b0;
        sample_x = 20'h00000;
        sample_y = 20'h00000;
        sample_z = 20'h00000;
        error_cnt = 0;
        checked = 0;
        cycles = 0;
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        reg_host_inst.rd(`OFS_STATUS, rd_data);
        chk("reset status", rd_data, 16'h0014);
        reg_host_inst.rd(`OFS_DECIMATION, rd_data);
        chk("reset decimation", rd_data, 16'h0000);
        $display("Test reset done");
        run(16'h0000, 3'h0);
        run(16'h0001, 3'h0);
        run(16'h0000, 3'h1);
        run(16'h0001, 3'h1);
        run(16'h0007, 3'h0);
        run(16'h0002, 3'h0);
        reg_host_inst.wr(`OFS_AVERAGING, 16'hFFFF);
        reg_host_inst.rd(`OFS_AVERAGING, rd_data);
        chk("averaging field", rd_data, 16'h0007);
        // Last result was twenty-two bits and its flag is already cleared
        reg_host_inst.rd(`OFS_STATUS, rd_data);
        chk("status cleared", rd_data, 16'h0016);
        reg_host_inst.rd(8'h28, rd_data);
        chk("unmapped read", rd_data, 16'h0000);
        $display("Test register port done");
        end_sim();
    end
endmodule

bind accel_output_width_formatter accel_fmt_assertions accel_fmt_assertions_inst
(
    .core_clk(core_clk),
    .resetn(resetn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .sample_valid(sample_valid),
    .result_valid(result_valid),
    .result_width(result_width)
);
